/* File: core/tcc_pkg.sv */
package tcc_pkg;

   localparam int unsigned TCC_ADDR_W     = 4;
   localparam int unsigned TCC_DATA_W     = 32;
   localparam int unsigned TCC_CNT_W      = 16;

   // Byte offsets on the register bus
   localparam logic [3:0]  TCC_OFS_CTRL   = 4'h0;
   localparam logic [3:0]  TCC_OFS_VALUE  = 4'h4;
   localparam logic [3:0]  TCC_OFS_CONFIG = 4'h8;

   // Field positions in the channel control/status register; TCC_BIT_CPWM is in the config register
   localparam int unsigned TCC_BIT_FLAG   = 7;
   localparam int unsigned TCC_BIT_IE     = 6;
   localparam int unsigned TCC_BIT_MODE_B = 5;
   localparam int unsigned TCC_BIT_MODE_A = 4;
   localparam int unsigned TCC_ELS_HI     = 3;
   localparam int unsigned TCC_ELS_LO     = 2;
   localparam int unsigned TCC_BIT_CPWM   = 0;

   // Edge/level select encodings
   localparam logic [1:0]  TCC_ELS_OFF    = 2'h0;
   localparam logic [1:0]  TCC_ELS_RISE   = 2'h1;
   localparam logic [1:0]  TCC_ELS_FALL   = 2'h2;
   localparam logic [1:0]  TCC_ELS_BOTH   = 2'h3;

   // Reset values
   localparam logic [7:0]  TCC_CTRL_RST   = 8'h00;
   localparam logic [15:0] TCC_VALUE_RST  = 16'h0000;

   typedef enum logic [1:0] {
      TCC_MODE_CAPTURE,
      TCC_MODE_COMPARE,
      TCC_MODE_EPWM,
      TCC_MODE_CPWM
   } tcc_mode_t;

   typedef struct packed {
      logic        flag;
      logic        irq_enable;
      logic        mode_b;
      logic        mode_a;
      logic [1:0]  els;
      logic        clear_armed;
      logic        center_pwm_select;
      logic [15:0] value;
      logic        pin_sync1;
      logic        pin_sync2;
      logic        pin_prev;
      logic        pin_out;
      logic        pin_oe;
      logic        ext_clock;
      logic        irq;
      logic        waitrequest;
      logic [31:0] readdata;
   } tcc_state_t;

endpackage

/* File: core/tcc_channel.sv */
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// R1: 8-bit register: flag7, ie6, modeB5, modeA4, els3:2
// R2: Capture mode sets flag on active pin edge
// R3: Compare or edge PWM flags on counter match
// R4: Center PWM flags on every counter match
// R5: Interrupt request when flag and enable set
// R6: Flag clears by read-while-set then write zero
// R7: New event restarts clear sequence, keeps flag
// R8: Reset clears flag; writing one has no effect
// R9: Interrupt enable read/write, reset clear, polling
// R10: Mode B set selects edge-aligned PWM
// R11: Mode B clear: A picks capture or compare
// R12: Edge/level zero disconnects pin in any mode
// R13: Released pin serves as external clock
// R14: Capture edges: 01 rise, 10 fall, 11 both
// R15: Compare pin: 01 toggle, 10 clear, 11 set
// R16: Edge PWM: 10 high-true, X1 low-true pulses
// R17: Center PWM polarity acts on up-count match
// R18: Unstable pin at mode change may flag edge
// R19: Software clears flag after reconfiguring channel
// R20: Center select forces all channels center PWM; here each channel holds its own select bit and forces only itself
// R21: Capture copies counter into channel value
// R22: Pin synchronised to bus clock before detection
module tcc_channel
   import tcc_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   input  wire logic [tcc_pkg::TCC_ADDR_W-1:0] avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [tcc_pkg::TCC_DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [tcc_pkg::TCC_DATA_W-1:0] avs_readdata,
   output logic                               avs_waitrequest,
   input  wire logic [tcc_pkg::TCC_CNT_W-1:0]  count_value,
   input  wire logic                          count_tick,
   input  wire logic                          count_up,
   input  wire logic                          count_wrap,
   input  wire logic                          channel_pin_in,
   output logic                               channel_pin_out,
   output logic                               channel_pin_oe,
   output logic                               ext_clock_out,
   output logic                               channel_irq
);
   import tcc_pkg::*;

   tcc_state_t r;
   tcc_state_t next_r;
   tcc_mode_t  mode;
   logic       bus_req;
   logic       do_write;
   logic       do_read;
   logic       match;
   logic       rise;
   logic       fall;
   logic       edge_hit;
   logic       event_hit;
   logic       high_true;

   always_comb begin
      if (r.center_pwm_select) begin
         mode = TCC_MODE_CPWM; // R20
      end else if (r.mode_b) begin
         mode = TCC_MODE_EPWM; // R10
      end else if (r.mode_a) begin
         mode = TCC_MODE_COMPARE; // R11
      end else begin
         mode = TCC_MODE_CAPTURE; // R11
      end
   end

   assign bus_req   = avs_read | avs_write;
   assign do_write  = avs_write & ~r.waitrequest;
   assign do_read   = avs_read & ~r.waitrequest;
   assign match     = count_tick & (count_value == r.value);
   // Edges seen only on the second synchroniser stage
   assign rise      = r.pin_sync2 & ~r.pin_prev; // R22
   assign fall      = ~r.pin_sync2 & r.pin_prev; // R22
   // Edge history runs in every mode, so a stale level can flag
   always_comb begin
      case (r.els)
         TCC_ELS_RISE: edge_hit = rise; // R14 R18
         TCC_ELS_FALL: edge_hit = fall; // R14 R18
         TCC_ELS_BOTH: edge_hit = rise | fall; // R14 R18
         default:      edge_hit = 1'b0; // R12
      endcase
   end
   always_comb begin
      case (mode)
         TCC_MODE_CAPTURE: event_hit = edge_hit; // R2
         TCC_MODE_COMPARE: event_hit = match; // R3
         TCC_MODE_EPWM:    event_hit = match; // R3
         TCC_MODE_CPWM:    event_hit = match; // R4
         default:          event_hit = 1'b0;
      endcase
   end
   assign high_true = (r.els == TCC_ELS_FALL);

   always_comb begin
      next_r = r;

      // Pin synchroniser
      next_r.pin_sync1 = channel_pin_in; // R22
      next_r.pin_sync2 = r.pin_sync1; // R22
      next_r.pin_prev  = r.pin_sync2;

      // Bus slave: one wait state, read data loaded during it
      next_r.waitrequest = 1'b1;
      if (bus_req && r.waitrequest) begin
         next_r.waitrequest = 1'b0;
         next_r.readdata    = '0;
         case (avs_address)
            TCC_OFS_CTRL: begin
               next_r.readdata[TCC_BIT_FLAG]   = r.flag;
               next_r.readdata[TCC_BIT_IE]     = r.irq_enable;
               next_r.readdata[TCC_BIT_MODE_B] = r.mode_b;
               next_r.readdata[TCC_BIT_MODE_A] = r.mode_a;
               next_r.readdata[TCC_ELS_HI:TCC_ELS_LO] = r.els;
            end
            TCC_OFS_VALUE:
               next_r.readdata[TCC_CNT_W-1:0] = r.value;
            TCC_OFS_CONFIG:
               next_r.readdata[TCC_BIT_CPWM] = r.center_pwm_select;
            default:
               next_r.readdata = '0;
         endcase
      end

      // Read of the control register while flagged arms the clear
      if (do_read && avs_address == TCC_OFS_CTRL && r.flag) begin
         next_r.clear_armed = 1'b1; // R6
      end

      if (do_write && avs_byteenable[0]) begin
         case (avs_address)
            TCC_OFS_CTRL: begin
               next_r.irq_enable = avs_writedata[TCC_BIT_IE]; // R9
               next_r.mode_b     = avs_writedata[TCC_BIT_MODE_B]; // R1
               next_r.mode_a     = avs_writedata[TCC_BIT_MODE_A]; // R1
               next_r.els = avs_writedata[TCC_ELS_HI:TCC_ELS_LO]; // R1
               // Writing one leaves the flag alone
               if (!avs_writedata[TCC_BIT_FLAG] && r.clear_armed) begin
                  next_r.flag = 1'b0; // R6 R8
               end
               next_r.clear_armed = 1'b0; // R6
            end
            TCC_OFS_VALUE:
               next_r.value[7:0] = avs_writedata[7:0];
            TCC_OFS_CONFIG:
               next_r.center_pwm_select = avs_writedata[TCC_BIT_CPWM];
            default: ;
         endcase
      end
      if (do_write && avs_byteenable[1] && avs_address == TCC_OFS_VALUE) begin
         next_r.value[15:8] = avs_writedata[15:8];
      end

      // Event wins over a clear in the same cycle and restarts it
      if (event_hit) begin
         next_r.flag        = 1'b1; // R2 R3 R4 R7
         next_r.clear_armed = 1'b0; // R7
      end
      if (mode == TCC_MODE_CAPTURE && edge_hit) begin
         next_r.value = count_value; // R21
      end

      // Pin action
      case (mode)
         TCC_MODE_COMPARE: begin
            if (match) begin
               case (r.els)
                  TCC_ELS_RISE: next_r.pin_out = ~r.pin_out; // R15
                  TCC_ELS_FALL: next_r.pin_out = 1'b0; // R15
                  TCC_ELS_BOTH: next_r.pin_out = 1'b1; // R15
                  default:      next_r.pin_out = r.pin_out; // R15
               endcase
            end
         end
         TCC_MODE_EPWM: begin
            // Match beats wrap so a zero value gives zero duty
            if (match) begin
               next_r.pin_out = ~high_true; // R16
            end else if (count_wrap) begin
               next_r.pin_out = high_true; // R16
            end
         end
         TCC_MODE_CPWM: begin
            if (match) begin
               next_r.pin_out = count_up ? ~high_true : high_true; // R17
            end
         end
         default: next_r.pin_out = r.pin_out;
      endcase
      next_r.pin_oe = (r.els != TCC_ELS_OFF) &&
                      (mode != TCC_MODE_CAPTURE); // R12
      next_r.ext_clock = (r.els == TCC_ELS_OFF) ? r.pin_sync2 : 1'b0; // R13

      next_r.irq = next_r.flag & next_r.irq_enable; // R5 R9
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r                   <= '0;
         r.flag              <= TCC_CTRL_RST[TCC_BIT_FLAG]; // R8
         r.irq_enable        <= TCC_CTRL_RST[TCC_BIT_IE]; // R9
         r.value             <= TCC_VALUE_RST;
         r.waitrequest       <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign avs_readdata    = r.readdata;
   assign avs_waitrequest = r.waitrequest;
   assign channel_pin_out = r.pin_out;
   assign channel_pin_oe  = r.pin_oe;
   assign ext_clock_out   = r.ext_clock;
   assign channel_irq     = r.irq;

endmodule

/* File: dv/tcc_checker.sv */
`timescale 1ns/1ns
module tcc_checker (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic        avs_waitrequest,
   input wire logic [3:0]  avs_address,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic [15:0] count_value,
   input wire logic        count_tick,
   input wire logic        count_up,
   input wire logic        count_wrap,
   input wire logic        channel_pin_in,
   input wire logic        channel_pin_out,
   input wire logic        channel_pin_oe,
   input wire logic        ext_clock_out,
   input wire logic        channel_irq
);
   logic wr_q;
   wire  wr_now = avs_write && !avs_waitrequest;
   wire  rd_now = avs_read && !avs_waitrequest;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) wr_q <= 1'b0;
      else wr_q <= wr_now;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_wait_one;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_wait_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_hi_zero;
      rd_now |-> avs_readdata[31:16] == 16'h0;
   endproperty
   property p_unmapped;
      rd_now && !(avs_address inside {4'h0, 4'h4, 4'h8})
         |-> avs_readdata == 32'h0;
   endproperty
   property p_irq_hold;
      channel_irq && !wr_now && !wr_q |=> channel_irq;
   endproperty
   property p_irq_cause;
      $rose(channel_irq) |-> $past(count_tick) || $past(count_tick, 2)
         || wr_q || $past(channel_pin_in, 2) != $past(channel_pin_in, 5);
   endproperty
   property p_pin_cause;
      $changed(channel_pin_out) |-> $past(count_tick) || $past(count_tick, 2)
         || $past(count_wrap) || wr_q || $past(wr_q);
   endproperty
   property p_oe_off;
      wr_now && avs_address == 4'h0 && avs_byteenable[0]
         && avs_writedata[3:2] == 2'h0 |-> ##2 !channel_pin_oe;
   endproperty
   property p_ext_excl;
      ext_clock_out |-> !channel_pin_oe;
   endproperty
   a_wait_one:   assert property (p_wait_one) else $error("no answer");
   a_wait_pulse: assert property (p_wait_pulse) else $error("long ack");
   a_hi_zero:    assert property (p_hi_zero) else $error("upper bits");
   a_unmapped:   assert property (p_unmapped) else $error("unmapped");
   a_irq_hold:   assert property (p_irq_hold) else $error("irq drop");
   a_irq_cause:  assert property (p_irq_cause) else $error("irq cause");
   a_pin_cause:  assert property (p_pin_cause) else $error("pin cause");
   a_oe_off:     assert property (p_oe_off) else $error("pin held");
   a_ext_excl:   assert property (p_ext_excl) else $error("ext and oe");
   c_irq:  cover property ($rose(channel_irq));
   c_oe:   cover property ($rose(channel_pin_oe));
   c_ext:  cover property ($rose(ext_clock_out));
endmodule
bind tcc_channel tcc_checker u_chk (.clk(clk), .rst_n(rst_n),
   .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
   .avs_waitrequest(avs_waitrequest), .avs_byteenable(avs_byteenable),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .count_value(count_value), .count_tick(count_tick), .count_up(count_up),
   .count_wrap(count_wrap), .channel_pin_in(channel_pin_in),
   .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
   .ext_clock_out(ext_clock_out), .channel_irq(channel_irq));

/* File: dv/tcc_pin_model.sv */
`timescale 1ns/1ns
module tcc_pin_model (
   input  wire logic clk,
   input  wire logic level_cmd,
   output logic      pin
);
   // Level moves on clock edges only and is held for many cycles
   always @(posedge clk) pin <= level_cmd;
endmodule

/* File: dv/timer_channel_control_tb_top.sv */
`timescale 1ns/1ns
module timer_channel_control_tb_top;
   import tcc_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [15:0] count_value = 16'h0;
   logic        count_tick = 1'b0, count_up = 1'b1, count_wrap = 1'b0;
   logic        avs_waitrequest, pin_out, pin_oe, ext_clk, irq, ext_pin;
   logic        pin_cmd = 1'b0;
   wire         pin_wire = pin_oe ? pin_out : ext_pin;
   int          error_cnt = 0, tests_run = 0;
   always #5 clk = ~clk;
   tcc_pin_model u_pin (.clk(clk), .level_cmd(pin_cmd), .pin(ext_pin));
   tcc_channel u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .count_value(count_value),
      .count_tick(count_tick), .count_up(count_up), .count_wrap(count_wrap),
      .channel_pin_in(pin_wire), .channel_pin_out(pin_out),
      .channel_pin_oe(pin_oe), .ext_clock_out(ext_clk), .channel_irq(irq));
   task automatic final_report;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         error_cnt++;
         final_report();
      end
   endtask
   task automatic tick(input logic [15:0] v, input logic up, input logic wrap);
      count_value <= v;
      count_up <= up;
      count_tick <= 1'b1;
      count_wrap <= wrap;
      @(posedge clk);
      count_tick <= 1'b0;
      count_wrap <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_reset;
      for (int a = 0; a < 16; a += 4) begin
         bus(0, 4'(a), 32'h0);
         chk(q, 32'h0);
      end
      bus(1, 4'h0, 32'h80);
      bus(0, 4'h0, 32'h0);
      chk(q, 32'h0);
      chk(irq, 1'b0);
   endtask
   task automatic t_capture;
      bus(1, 4'h0, 32'h4c);
      count_value <= 16'h1234;
      pin_cmd <= 1'b1;
      repeat (6) @(posedge clk);
      chk(irq, 1'b1);
      bus(0, 4'h4, 32'h0);
      chk(q, 32'h1234);
      bus(0, 4'h0, 32'h0);
      chk(q, 32'hcc);
      pin_cmd <= 1'b0;
      repeat (6) @(posedge clk);
      bus(1, 4'h0, 32'h4c);
      bus(0, 4'h0, 32'h0);
      chk(q, 32'hcc);
      bus(1, 4'h0, 32'h48);
      chk(irq, 1'b0);
      pin_cmd <= 1'b1;
      repeat (6) @(posedge clk);
      chk(irq, 1'b0);
      pin_cmd <= 1'b0;
      repeat (6) @(posedge clk);
      chk(irq, 1'b1);
   endtask
   task automatic t_compare;
      bus(1, 4'h4, 32'h10);
      bus(0, 4'h0, 32'h0);
      bus(1, 4'h0, 32'h1c);
      for (int e = 3; e > 0; e--) begin
         bus(1, 4'h0, 32'h10 | e << 2);
         tick(16'h10, 1'b1, 1'b0);
         chk(pin_out, e[0]);
         chk(pin_oe, 1'b1);
      end
      bus(0, 4'h0, 32'h0);
      chk(q[7], 1'b1);
   endtask
   task automatic t_pwm;
      for (int e = 2; e > 0; e--) begin
         bus(1, 4'h0, 32'h20 | e << 2);
         tick(16'h0, 1'b1, 1'b1);
         chk(pin_out, !e[0]);
         tick(16'h10, 1'b1, 1'b0);
         chk(pin_out, e[0]);
      end
      bus(1, 4'h8, 32'h1);
      bus(0, 4'h0, 32'h0);
      for (int e = 2; e > 0; e--) begin
         bus(1, 4'h0, 32'h10 | e << 2);
         tick(16'h10, 1'b1, 1'b0);
         chk(pin_out, e[0]);
         tick(16'h10, 1'b0, 1'b0);
         chk(pin_out, !e[0]);
      end
      bus(0, 4'h0, 32'h0);
      chk(q[7], 1'b1);
      bus(1, 4'h8, 32'h0);
   endtask
   task automatic t_gpio;
      bus(1, 4'h0, 32'h30);
      // Enable follows the field one cycle later
      @(posedge clk);
      chk(pin_oe, 1'b0);
      pin_cmd <= 1'b1;
      repeat (5) @(posedge clk);
      chk(ext_clk, 1'b1);
      pin_cmd <= 1'b0;
      repeat (5) @(posedge clk);
      chk(ext_clk, 1'b0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_capture();
      t_compare();
      t_pwm();
      t_gpio();
      final_report();
   end
endmodule
